// ==== design/aimt_exec.sv ====
`default_nettype none
// Notes on behaviour
// RL1: load E3 reads byte at pair into register, then pair+1; 10 cycles.
// RL2: even pair code uses program memory, odd uses external data memory.
// RL3: these instructions never change any flag bit.
// RL4: source register or memory byte stays unchanged; only dest and pair.
// RL5: store F2 decrements pair first, writes register there; 14 cycles.
// RL6: store F3 increments pair first, writes register there; 14 cycles.
// RL7: pair steps as one 16-bit value with carry or borrow across bytes.
// RL8: address high byte from even register, low byte from odd register.
// RL9: two-byte op; second byte upper nibble register, lower nibble pair.
// RL10: pair register number is the pair code with its low bit cleared.
module aimt_exec (
  input  wire logic       i_clock,      // cpu clock
  input  wire logic       i_nrst,       // async reset, active low
  input  wire logic       i_start,      // pulse: new instruction
  input  wire logic [7:0] i_opcode,     // first instruction byte
  input  wire logic [7:0] i_operand,    // second instruction byte
  input  wire logic [7:0] i_reg_rdata,  // working register read data
  input  wire logic [7:0] i_mem_rdata,  // memory read data
  output logic            o_busy,       // instruction in progress
  output logic            o_done,       // pulse: instruction finished
  output logic            o_illegal,    // pulse: opcode not handled
  output logic [3:0]      o_reg_raddr,  // working register read index
  output logic            o_reg_we,     // working register write strobe
  output logic [3:0]      o_reg_waddr,  // working register write index
  output logic [7:0]      o_reg_wdata,  // working register write data
  output logic            o_mem_re,     // memory read strobe
  output logic            o_mem_we,     // memory write strobe
  output logic            o_mem_ext,    // 1 external data, 0 program
  output logic [15:0]     o_mem_addr,   // memory address
  output logic [7:0]      o_mem_wdata,  // memory write data
  output logic            o_flags_we    // flag write enable, always 0
);
  import aimt_pkg::*;

  aimt_state_t state_ff, nxt_state;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic [7:0]  opc_ff, nxt_opc;
  logic [3:0]  reg_ff, nxt_reg;
  logic [3:0]  pair_ff, nxt_pair;
  logic        ext_ff, nxt_ext;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0]  data_ff, nxt_data;
  logic        hi_ff, nxt_hi;
  logic        pend_ff, nxt_pend;
  logic [15:0] stepped;
  logic        is_load, is_dec;

  logic        busy_ff, nxt_busy, done_ff, nxt_done, ill_ff, nxt_ill;
  logic [3:0]  raddr_ff, nxt_raddr, waddr_ff, nxt_waddr;
  logic        rwe_ff, nxt_rwe, mre_ff, nxt_mre, mwe_ff, nxt_mwe;
  logic [7:0]  rwd_ff, nxt_rwd, mwd_ff, nxt_mwd;

  assign is_load = (opc_ff == AIMT_OPC_LOAD_POST_INC);
  assign is_dec  = (opc_ff == AIMT_OPC_STORE_PRE_DEC);

  aimt_addr_step u_step (
    .i_addr (addr_ff),
    .i_dec  (is_dec),
    .o_addr (stepped)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_opc   = opc_ff;
    nxt_reg   = reg_ff;
    nxt_pair  = pair_ff;
    nxt_ext   = ext_ff;
    nxt_addr  = addr_ff;
    nxt_data  = data_ff;
    nxt_hi    = hi_ff;
    nxt_pend  = 1'b0;
    nxt_busy  = busy_ff;
    nxt_done  = 1'b0;
    nxt_ill   = 1'b0;
    nxt_raddr = raddr_ff;
    nxt_waddr = waddr_ff;
    nxt_rwe   = 1'b0;
    nxt_rwd   = rwd_ff;
    nxt_mre   = 1'b0;
    nxt_mwe   = 1'b0;
    nxt_mwd   = mwd_ff;
    if (state_ff != AIMT_IDLE) begin
      nxt_cnt = cnt_ff + AIMT_CYC_ONE;
    end
    case (state_ff)
      AIMT_IDLE: begin
        if (i_start) begin
          if (i_opcode == AIMT_OPC_LOAD_POST_INC ||
              i_opcode == AIMT_OPC_STORE_PRE_DEC ||
              i_opcode == AIMT_OPC_STORE_PRE_INC) begin
            nxt_opc   = i_opcode;
            nxt_reg   = i_operand[AIMT_NIB_HI +: AIMT_NIB_W]; // RL9
            nxt_pair  = i_operand[0 +: AIMT_NIB_W]
                        & AIMT_PAIR_MASK; // RL10
            nxt_ext   = i_operand[AIMT_SPACE_BIT]; // RL2
            nxt_raddr = i_operand[0 +: AIMT_NIB_W] & AIMT_PAIR_MASK; // RL8
            nxt_hi    = 1'b1;
            nxt_cnt   = AIMT_CYC_ONE;
            nxt_busy  = 1'b1;
            nxt_state = AIMT_RDPR;
          end else begin
            nxt_ill = 1'b1;
          end
        end
      end
      AIMT_RDPR: begin
        // read data lags the index by one cycle
        // indices are issued back to back, so the data register index
        // goes out while the low byte comes back
        if (hi_ff && raddr_ff == pair_ff) begin
          nxt_raddr = pair_ff | AIMT_ODD_BIT;
        end else if (hi_ff) begin
          nxt_addr[15:8] = i_reg_rdata; // RL8
          nxt_raddr      = reg_ff;
          nxt_hi         = 1'b0;
        end else begin
          nxt_addr[7:0] = i_reg_rdata; // RL8
          nxt_state     = AIMT_ADJ;
        end
      end
      AIMT_ADJ: begin
        nxt_data = i_reg_rdata;
        if (!is_load) begin
          nxt_addr = stepped; // RL5 RL6 RL7
        end
        nxt_state = AIMT_MEM;
      end
      AIMT_MEM: begin
        if (is_load) begin
          nxt_mre = 1'b1; // RL1
        end else begin
          nxt_mwe = 1'b1; // RL5 RL6
          nxt_mwd = data_ff; // RL4
        end
        nxt_state = AIMT_WAIT;
      end
      AIMT_WAIT: begin
        // memory answers one edge after it sees the strobe
        nxt_pend = mre_ff;
        if (is_load && pend_ff) begin
          nxt_rwe   = 1'b1; // RL1
          nxt_waddr = reg_ff;
          nxt_rwd   = i_mem_rdata;
          nxt_addr  = stepped; // RL1 RL7
        end
        if (cnt_ff == ((is_load ? AIMT_CYC_LOAD : AIMT_CYC_STORE)
                       - AIMT_CYC_ONE)) begin
          nxt_state = AIMT_DONE;
        end
      end
      AIMT_DONE: begin
        // pair write-back is left to the register-file owner via o_mem_addr
        nxt_done  = 1'b1;
        nxt_busy  = 1'b0;
        nxt_state = AIMT_IDLE;
      end
      default: begin
        nxt_state = AIMT_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= AIMT_IDLE;
      cnt_ff   <= 5'h00;
      opc_ff   <= 8'h00;
      reg_ff   <= 4'h0;
      pair_ff  <= 4'h0;
      ext_ff   <= 1'b0;
      addr_ff  <= 16'h0000;
      data_ff  <= 8'h00;
      hi_ff    <= 1'b0;
      pend_ff  <= 1'b0;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      ill_ff   <= 1'b0;
      raddr_ff <= 4'h0;
      waddr_ff <= 4'h0;
      rwe_ff   <= 1'b0;
      rwd_ff   <= 8'h00;
      mre_ff   <= 1'b0;
      mwe_ff   <= 1'b0;
      mwd_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      opc_ff   <= nxt_opc;
      reg_ff   <= nxt_reg;
      pair_ff  <= nxt_pair;
      ext_ff   <= nxt_ext;
      addr_ff  <= nxt_addr;
      data_ff  <= nxt_data;
      hi_ff    <= nxt_hi;
      pend_ff  <= nxt_pend;
      busy_ff  <= nxt_busy;
      done_ff  <= nxt_done;
      ill_ff   <= nxt_ill;
      raddr_ff <= nxt_raddr;
      waddr_ff <= nxt_waddr;
      rwe_ff   <= nxt_rwe;
      rwd_ff   <= nxt_rwd;
      mre_ff   <= nxt_mre;
      mwe_ff   <= nxt_mwe;
      mwd_ff   <= nxt_mwd;
    end
  end

  assign o_busy      = busy_ff;
  assign o_done      = done_ff;
  assign o_illegal   = ill_ff;
  assign o_reg_raddr = raddr_ff;
  assign o_reg_we    = rwe_ff;
  assign o_reg_waddr = waddr_ff;
  assign o_reg_wdata = rwd_ff;
  assign o_mem_re    = mre_ff;
  assign o_mem_we    = mwe_ff;
  assign o_mem_ext   = ext_ff; // RL2
  assign o_mem_addr  = addr_ff;
  assign o_mem_wdata = mwd_ff;
  assign o_flags_we  = 1'b0; // RL3
endmodule // aimt_exec
`default_nettype wire

// ==== design/aimt_pkg.sv ====
`default_nettype none
package aimt_pkg;
  localparam logic [7:0] AIMT_OPC_LOAD_POST_INC  = 8'hE3;
  localparam logic [7:0] AIMT_OPC_STORE_PRE_DEC  = 8'hF2;
  localparam logic [7:0] AIMT_OPC_STORE_PRE_INC  = 8'hF3;
  localparam logic [4:0] AIMT_CYC_LOAD           = 5'h0A;
  localparam logic [4:0] AIMT_CYC_STORE          = 5'h0E;
  localparam logic [4:0] AIMT_CYC_ONE            = 5'h01;
  localparam int         AIMT_NIB_HI             = 4;
  localparam int         AIMT_NIB_W              = 4;
  localparam int         AIMT_SPACE_BIT          = 0;
  localparam logic [3:0] AIMT_PAIR_MASK          = 4'hE;
  localparam logic [3:0] AIMT_ODD_BIT            = 4'h1;
  localparam logic [15:0] AIMT_ONE16             = 16'h0001;

  typedef enum logic [2:0] {
    AIMT_IDLE  = 3'b000,
    AIMT_RDPR  = 3'b001,
    AIMT_ADJ   = 3'b010,
    AIMT_MEM   = 3'b011,
    AIMT_WAIT  = 3'b100,
    AIMT_DONE  = 3'b101
  } aimt_state_t;
endpackage
`default_nettype wire

// ==== design/aimt_addr_step.sv ====
`default_nettype none
module aimt_addr_step (
  input  wire logic [15:0] i_addr,   // current pair value
  input  wire logic        i_dec,    // 1 subtract, 0 add
  output logic      [15:0] o_addr    // stepped value
);
  import aimt_pkg::*;
  // full 16-bit step so carry/borrow crosses bytes
  assign o_addr = i_dec ? (i_addr - AIMT_ONE16)
                        : (i_addr + AIMT_ONE16); // RL7
endmodule // aimt_addr_step
`default_nettype wire

// ==== dv/aimt_exec_props.sv ====
`default_nettype none
module aimt_exec_props
  import aimt_pkg::*;
(
  input wire logic       i_clock,     // clk
  input wire logic       i_nrst,      // rst
  input wire logic       i_start,     // go
  input wire logic [7:0] i_opcode,    // op
  input wire logic [7:0] i_operand,   // regs
  input wire logic       o_busy,      // busy
  input wire logic       o_done,      // end
  input wire logic [3:0] o_reg_raddr, // rd idx
  input wire logic       o_reg_we,    // wr
  input wire logic [3:0] o_reg_waddr, // wr idx
  input wire logic       o_mem_re,    // rd
  input wire logic       o_mem_we,    // wr
  input wire logic       o_mem_ext,   // space
  input wire logic       o_flags_we   // flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [7:0] op_ff;
  logic       tk, ld, st;
  assign tk = i_start && !o_busy;
  assign ld = tk && i_opcode == AIMT_OPC_LOAD_POST_INC;
  // both stores differ only in bit 0
  assign st = tk && i_opcode[7:1] == AIMT_OPC_STORE_PRE_DEC[7:1];
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst) op_ff <= 8'h00;
    else if (tk) op_ff <= i_operand;
  sequence pair_rd;
    ##1 o_reg_raddr == (op_ff[3:0] & AIMT_PAIR_MASK)
    ##1 o_reg_raddr == (op_ff[3:0] | AIMT_ODD_BIT);
  endsequence
  // done is registered: seen high one sample after the tenth edge
  AST_LOAD_LEN: assert property (ld |-> ##11 o_done)
    else $error("load length wrong");
  AST_STORE_LEN: assert property (st |-> ##15 o_done)
    else $error("store length wrong");
  AST_FLAGS: assert property (!o_flags_we)
    else $error("flags written");
  AST_SRC_KEEP: assert property (st |=> !o_reg_we until o_done)
    else $error("register written by store");
  AST_SPACE: assert property ((o_mem_re || o_mem_we) |->
    o_mem_ext == op_ff[AIMT_SPACE_BIT]) else $error("wrong space");
  AST_PAIR_RD: assert property ((ld || st) |-> pair_rd)
    else $error("pair read order wrong");
  AST_STORE_SRC: assert property (
    st |-> pair_rd ##1 o_reg_raddr == op_ff[7:4])
    else $error("store source index wrong");
  AST_LOAD_DST: assert property (
    o_reg_we |-> o_reg_waddr == op_ff[7:4] && !o_mem_we)
    else $error("load destination wrong");
endmodule // aimt_exec_props
bind aimt_exec aimt_exec_props aimt_exec_props_i (.*);
`default_nettype wire

// ==== dv/aimt_far.sv ====
`default_nettype none
module aimt_far (
  input  wire logic        i_clock, // clk
  input  wire logic [3:0]  i_raddr, // reg rd idx
  input  wire logic        i_we,    // reg wr
  input  wire logic [3:0]  i_waddr, // reg wr idx
  input  wire logic [7:0]  i_wdata, // reg wr data
  input  wire logic        i_re,    // mem rd
  input  wire logic        i_mwe,   // mem wr
  input  wire logic        i_ext,   // space
  input  wire logic [15:0] i_addr,  // address
  input  wire logic [7:0]  i_mdata, // mem wr data
  output logic      [7:0]  o_rdata, // reg data
  output logic      [7:0]  o_mdata  // mem data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  regs [16];
  logic [16:0] wr;
  logic [7:0]  wd;
  int          wn = 0;
  always @(posedge i_clock) begin
    o_rdata <= regs[i_raddr];
    if (i_we) regs[i_waddr] <= i_wdata;
    // contents follow the address, so the two spaces differ except where the high address byte is 5A
    if (i_re) o_mdata <= i_addr[7:0] ^ (i_ext ? 8'h5A : i_addr[15:8]);
    else o_mdata <= ~o_mdata; // stale byte is inverted each cycle, so a sample one cycle late looks wrong
    if (i_mwe) begin
      wr <= {i_ext, i_addr};
      wd <= i_mdata;
      wn <= wn + 1;
    end
  end
endmodule // aimt_far
`default_nettype wire

// ==== dv/testbench.sv ====
`default_nettype none
module testbench;
  import aimt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0, i_nrst = 1'b0, i_start = 1'b0;
  logic [7:0]  i_opcode = 8'h00, i_operand = 8'h00;
  logic [7:0]  i_reg_rdata, i_mem_rdata, o_reg_wdata, o_mem_wdata;
  logic        o_busy, o_done, o_illegal, o_reg_we, o_mem_re, o_mem_we;
  logic        o_mem_ext, o_flags_we;
  logic [3:0]  o_reg_raddr, o_reg_waddr;
  logic [15:0] o_mem_addr;
  int          fails = 0, n_checks = 0;
  always #10 i_clock = ~i_clock;
  aimt_exec aimt_exec_i (.*);
  aimt_far aimt_far_i (.i_clock, .i_raddr(o_reg_raddr), .i_we(o_reg_we),
    .i_waddr(o_reg_waddr), .i_wdata(o_reg_wdata), .i_re(o_mem_re),
    .i_mwe(o_mem_we), .i_ext(o_mem_ext), .i_addr(o_mem_addr),
    .i_mdata(o_mem_wdata), .o_rdata(i_reg_rdata), .o_mdata(i_mem_rdata));
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask
  // n counts edges from take to done
  task automatic run(input logic [7:0] op, opd, output int n);
    @(posedge i_clock);
    #1 i_opcode = op;
    i_operand = opd;
    i_start = 1'b1;
    @(posedge i_clock);
    #1 i_start = 1'b0;
    n = 0;
    while (o_done !== 1'b1) begin
      @(posedge i_clock);
      #1 n++;
      if (n > 40) begin
        fails++;
        finish_test();
      end
    end
  endtask
  task automatic t_load(input logic ext);
    int n, w;
    aimt_far_i.regs[6] = 8'h10;
    aimt_far_i.regs[7] = 8'hFF;
    w = aimt_far_i.wn;
    run(AIMT_OPC_LOAD_POST_INC, {4'h8, 3'h3, ext}, n);
    chk(n, 32'h0000000A);
    chk(32'(aimt_far_i.regs[8]), ext ? 32'hA5 : 32'hEF);
    chk(32'(o_mem_addr), 32'h00001100);
    chk(aimt_far_i.wn - w, 32'h00000000);
  endtask
  task automatic t_store(input logic [7:0] op, input logic ext,
                         input logic [15:0] pr, ea);
    int n;
    aimt_far_i.regs[0] = 8'h77;
    {aimt_far_i.regs[6], aimt_far_i.regs[7]} = pr;
    run(op, {4'h0, 3'h3, ext}, n);
    chk(n, 32'h0000000E);
    chk({7'h00, aimt_far_i.wr, aimt_far_i.wd}, {7'h00, ext, ea, 8'h77});
    chk(32'(aimt_far_i.regs[0]), 32'h00000077);
    chk(32'(o_mem_addr), 32'(ea));
  endtask
  task automatic t_illegal();
    @(posedge i_clock);
    #1 i_opcode = 8'hE2;
    i_start = 1'b1;
    @(posedge i_clock);
    #1 i_start = 1'b0;
    chk({o_illegal, o_busy}, 2'b10);
    @(posedge i_clock);
    #1 chk({o_illegal, o_busy}, 2'b00);
  endtask
  initial begin
    repeat (5) @(posedge i_clock);
    #1 i_nrst = 1'b1;
    t_illegal();
    for (int e = 0; e < 2; e++) begin
      t_load(e[0]);
      t_store(AIMT_OPC_STORE_PRE_DEC, e[0], 16'h3000, 16'h2FFF);
      t_store(AIMT_OPC_STORE_PRE_INC, e[0], 16'h21FF, 16'h2200);
    end
    finish_test();
  end
endmodule // testbench
`default_nettype wire
